/* File: rtl/supply_network_object_map.sv */
// Functional notes
// - questionable status: 32-bit, get-only instance 11
// - questionable bits are live, unlatched
// - reading questionable status clears nothing
// - hard faults at bits 0,4,5,6
// - soft trips at bits 1,2,3
// - regulation states occupy bits 7 to 10
// - bit 11 ors all soft faults
// - bit 12 ors all hard faults
// - bits 13-15: interlock, power loss, input fault
// - current, voltage, power measurements are read-only
// - set-points written 513/515/517, read next
// - trip limits written 769-775, read next
// - rising slews written 1025-1029, read next
// - falling slews written 1033-1037, read next
// - control selection written 1283, read 1284
// - write 1793 reloads factory defaults
// - lock written 1795, read 1794; blocks changes
// - sense settings written 1798, read 1799
// - target origin written 1802, read 1803
// - live status read-only on instance 13
// - output enable 15/16 reads active state
`timescale 1ns/10ps
module supply_network_object_map
  import supply_map_pkg::*;
#(
  parameter int NUM_PARAMS = 16
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [INST_W-1:0] req_instance_in,
  input wire logic [DATA_W-1:0] req_data_in,
  input wire logic [6:0] fault_flags_in,
  input wire logic [3:0] regulation_state_in,
  input wire logic interlock_open_in,
  input wire logic input_power_loss_in,
  input wire logic user_input_fault_in,
  input wire logic power_active_in,
  input wire logic [DATA_W-1:0] live_status_in,
  input wire logic [DATA_W-1:0] read_avg_current_in,
  input wire logic [DATA_W-1:0] read_avg_voltage_in,
  input wire logic [DATA_W-1:0] read_dc_power_in,
  input wire logic [NUM_PARAMS*DATA_W-1:0] factory_defaults_in,
  output logic resp_valid_out,
  output logic [1:0] resp_status_out,
  output logic [DATA_W-1:0] resp_data_out,
  output logic output_enable_out,
  output logic [DATA_W-1:0] current_target_out,
  output logic [DATA_W-1:0] voltage_target_out,
  output logic [DATA_W-1:0] power_target_out,
  output logic [DATA_W-1:0] active_up_slew_out,
  output logic [DATA_W-1:0] active_down_slew_out,
  output logic [DATA_W-1:0] control_selection_out,
  output logic [DATA_W-1:0] sense_location_cfg_out,
  output logic [DATA_W-1:0] target_origin_select_out,
  output logic lock_out
);
  // parameter slots: 0-2 targets, 3-6 limits, 7-9 up slews, 10-12 down slews,
  // 13 control, 14 sense, 15 origin
  logic [DATA_W-1:0] param_q [NUM_PARAMS];
  logic out_en_q;
  logic lock_q;
  logic [DATA_W-1:0] ques_q;
  logic [6:0] fault_s1_q, fault_s2_q;
  logic [3:0] reg_s1_q, reg_s2_q;
  logic [2:0] misc_s1_q, misc_s2_q;
  logic pwr_s1_q, pwr_s2_q;

  // status pins come from analog/firmware domains: two-stage sync
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      fault_s1_q <= '0;
      fault_s2_q <= '0;
      reg_s1_q <= '0;
      reg_s2_q <= '0;
      misc_s1_q <= '0;
      misc_s2_q <= '0;
      pwr_s1_q <= 1'b0;
      pwr_s2_q <= 1'b0;
    end else begin
      fault_s1_q <= fault_flags_in;
      fault_s2_q <= fault_s1_q;
      reg_s1_q <= regulation_state_in;
      reg_s2_q <= reg_s1_q;
      misc_s1_q <= {user_input_fault_in, input_power_loss_in, interlock_open_in};
      misc_s2_q <= misc_s1_q;
      pwr_s1_q <= power_active_in;
      pwr_s2_q <= pwr_s1_q;
    end
  end

  // fault_flags_in carries bits 0-6 already in questionable order
  wire logic soft_any = fault_s2_q[Q_OC_TRIP] | fault_s2_q[Q_OV_TRIP] | fault_s2_q[Q_OP_TRIP];
  wire logic hard_any = fault_s2_q[Q_OV_PROT] | fault_s2_q[Q_OC_PROT] | fault_s2_q[Q_OT_PROT] | fault_s2_q[Q_SENSE_LOSS];
  logic [DATA_W-1:0] ques_d;
  always_comb begin
    ques_d = '0;
    ques_d[Q_SENSE_LOSS:Q_OV_PROT] = fault_s2_q;
    ques_d[Q_REG_LO+3:Q_REG_LO] = reg_s2_q;
    ques_d[Q_SOFT_SUM] = soft_any;
    ques_d[Q_HARD_SUM] = hard_any;
    ques_d[Q_UIF:Q_INTERLOCK] = misc_s2_q;
  end

  // recomputed every cycle, so bits fall three cycles after the cause does (two sync stages plus this register)
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) ques_q <= '0;
    else ques_q <= ques_d;
  end

  // request decode
  wire logic [INST_W-1:0] inst = req_instance_in;
  wire logic [INST_W-1:0] tgt_off = inst - INST_TARGET_BASE;
  wire logic [INST_W-1:0] lim_off = inst - INST_LIMIT_BASE;
  wire logic [INST_W-1:0] up_off = inst - INST_UP_SLEW_BASE;
  wire logic [INST_W-1:0] dn_off = inst - INST_DOWN_SLEW_BASE;
  wire logic tgt_hit = tgt_off < 12'h006;
  wire logic lim_hit = lim_off < 12'h008;
  wire logic up_hit = up_off < 12'h006;
  wire logic dn_hit = dn_off < 12'h006;
  wire logic is_rd_half = inst[0] == 1'b0;
  logic param_hit;
  logic [3:0] param_idx;
  always_comb begin
    param_hit = 1'b1;
    param_idx = 4'h0;
    if (tgt_hit) param_idx = 4'(tgt_off[2:1]);
    else if (lim_hit) param_idx = 4'(4'h3 + 4'(lim_off[2:1]));
    else if (up_hit) param_idx = 4'(4'h7 + 4'(up_off[2:1]));
    else if (dn_hit) param_idx = 4'(4'hA + 4'(dn_off[2:1]));
    else if (inst == INST_CTRL_WR || inst == INST_CTRL_RD) param_idx = 4'hD;
    else if (inst == INST_SENSE_WR || inst == INST_SENSE_RD) param_idx = 4'hE;
    else if (inst == INST_ORIGIN_WR || inst == INST_ORIGIN_RD) param_idx = 4'hF;
    else param_hit = 1'b0;
  end
  // sense/origin pairs sit on even write instances, others on odd
  wire logic odd_write_grp = tgt_hit | lim_hit | up_hit | dn_hit | inst == INST_CTRL_WR || inst == INST_CTRL_RD;
  wire logic param_is_rd = odd_write_grp ? is_rd_half : !is_rd_half;

  wire logic param_wr = param_hit & !param_is_rd;
  wire logic param_rd = param_hit & param_is_rd;
  wire logic wr_ok = param_wr | inst == INST_OUT_WR | inst == INST_LOCK_WR | inst == INST_RESTORE_WR;
  logic rd_ok;
  logic [DATA_W-1:0] rd_data;
  always_comb begin
    rd_ok = 1'b1;
    rd_data = '0;
    if (param_rd) rd_data = param_q[param_idx];
    else if (inst == INST_QUES_RD) rd_data = ques_q;
    else if (inst == INST_LIVE_RD) rd_data = live_status_in;
    else if (inst == INST_CURR_RD) rd_data = read_avg_current_in;
    else if (inst == INST_VOLT_RD) rd_data = read_avg_voltage_in;
    else if (inst == INST_PWR_RD) rd_data = read_dc_power_in;
    else if (inst == INST_OUT_RD) rd_data = DATA_W'(out_en_q & pwr_s2_q);
    else if (inst == INST_LOCK_RD) rd_data = DATA_W'(lock_q);
    else rd_ok = 1'b0;
  end

  // the lock instance itself must stay writable or the unit could never unlock
  wire logic locked_out = lock_q & inst != INST_LOCK_WR;
  wire logic do_write = req_valid_in & req_write_in & wr_ok & !locked_out;
  wire logic req_ok = req_write_in ? (wr_ok & !locked_out) : rd_ok;

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < NUM_PARAMS; i++) param_q[i] <= PARAM_RESET;
    end else if (do_write && inst == INST_RESTORE_WR) begin
      for (int i = 0; i < NUM_PARAMS; i++) param_q[i] <= factory_defaults_in[i*DATA_W +: DATA_W];
    end else if (do_write && param_wr) begin
      param_q[param_idx] <= req_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      out_en_q <= 1'b0;
      lock_q <= 1'b0;
    end else if (do_write && inst == INST_OUT_WR) begin
      out_en_q <= req_data_in[0];
    end else if (do_write && inst == INST_LOCK_WR) begin
      lock_q <= req_data_in[0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      resp_valid_out <= 1'b0;
      resp_status_out <= ST_OK;
      resp_data_out <= '0;
    end else begin
      resp_valid_out <= req_valid_in;
      if (req_valid_in) begin
        resp_status_out <= req_ok ? ST_OK : ST_ERR;
        resp_data_out <= (!req_write_in && rd_ok) ? rd_data : '0;
      end
    end
  end

  // slew follows the regulation state; resistance regulation has no slew, so 0
  logic [DATA_W-1:0] up_sel, dn_sel;
  always_comb begin
    up_sel = '0;
    dn_sel = '0;
    if (reg_s2_q[0]) begin
      up_sel = param_q[7];
      dn_sel = param_q[10];
    end else if (reg_s2_q[1]) begin
      up_sel = param_q[8];
      dn_sel = param_q[11];
    end else if (reg_s2_q[3]) begin
      up_sel = param_q[9];
      dn_sel = param_q[12];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      output_enable_out <= 1'b0;
      current_target_out <= '0;
      voltage_target_out <= '0;
      power_target_out <= '0;
      active_up_slew_out <= '0;
      active_down_slew_out <= '0;
      control_selection_out <= '0;
      sense_location_cfg_out <= '0;
      target_origin_select_out <= '0;
      lock_out <= 1'b0;
    end else begin
      output_enable_out <= out_en_q & !hard_any;
      current_target_out <= param_q[0];
      voltage_target_out <= param_q[1];
      power_target_out <= param_q[2];
      active_up_slew_out <= up_sel;
      active_down_slew_out <= dn_sel;
      control_selection_out <= param_q[13];
      sense_location_cfg_out <= param_q[14];
      target_origin_select_out <= param_q[15];
      lock_out <= lock_q;
    end
  end
endmodule

/* File: common/supply_map_pkg.sv */
package supply_map_pkg;
  localparam int INST_W = 12;
  localparam int DATA_W = 32;
  // read-only instances, plus the output enable write/read pair
  localparam logic [11:0] INST_QUES_RD = 12'h00B;
  localparam logic [11:0] INST_LIVE_RD = 12'h00D;
  localparam logic [11:0] INST_OUT_WR = 12'h00F;
  localparam logic [11:0] INST_OUT_RD = 12'h010;
  localparam logic [11:0] INST_CURR_RD = 12'h101;
  localparam logic [11:0] INST_VOLT_RD = 12'h102;
  localparam logic [11:0] INST_PWR_RD = 12'h103;
  // first write instance of each parameter group; read is write plus one, except lock (read one below) and restore (no read)
  localparam logic [11:0] INST_TARGET_BASE = 12'h201;
  localparam logic [11:0] INST_LIMIT_BASE = 12'h301;
  localparam logic [11:0] INST_UP_SLEW_BASE = 12'h401;
  localparam logic [11:0] INST_DOWN_SLEW_BASE = 12'h409;
  localparam logic [11:0] INST_CTRL_WR = 12'h503;
  localparam logic [11:0] INST_CTRL_RD = 12'h504;
  localparam logic [11:0] INST_RESTORE_WR = 12'h701;
  localparam logic [11:0] INST_LOCK_RD = 12'h702;
  localparam logic [11:0] INST_LOCK_WR = 12'h703;
  localparam logic [11:0] INST_SENSE_WR = 12'h706;
  localparam logic [11:0] INST_SENSE_RD = 12'h707;
  localparam logic [11:0] INST_ORIGIN_WR = 12'h70A;
  localparam logic [11:0] INST_ORIGIN_RD = 12'h70B;
  // questionable bit positions
  localparam int Q_OV_PROT = 0;
  localparam int Q_OC_TRIP = 1;
  localparam int Q_OV_TRIP = 2;
  localparam int Q_OP_TRIP = 3;
  localparam int Q_OC_PROT = 4;
  localparam int Q_OT_PROT = 5;
  localparam int Q_SENSE_LOSS = 6;
  localparam int Q_REG_LO = 7;
  localparam int Q_SOFT_SUM = 11;
  localparam int Q_HARD_SUM = 12;
  localparam int Q_INTERLOCK = 13;
  localparam int Q_PWR_LOSS = 14;
  localparam int Q_UIF = 15;
  localparam logic [31:0] PARAM_RESET = 32'h0000_0000;
  localparam logic [1:0] ST_OK = 2'h0;
  localparam logic [1:0] ST_ERR = 2'h1;
endpackage

/* File: verification/supply_map_assertions.sv */
`timescale 1ns/10ps
module supply_map_assertions
  import supply_map_pkg::*;
#(
  parameter int NUM_PARAMS = 16
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic [INST_W-1:0] req_instance_in,
  input wire logic resp_valid_out,
  input wire logic [1:0] resp_status_out,
  input wire logic [DATA_W-1:0] resp_data_out,
  input wire logic [DATA_W-1:0] current_target_out,
  input wire logic lock_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  wire ques_get = req_valid_in && !req_write_in && (req_instance_in == INST_QUES_RD);
  sequence s_ques_req;
    ques_get;
  endsequence
  sequence s_locked_set;
    lock_out && req_valid_in && req_write_in && (req_instance_in == INST_TARGET_BASE);
  endsequence
  a_resp_one_cycle: assert property (req_valid_in |=> resp_valid_out)
    else $error("no response one cycle after request");
  a_resp_no_spur: assert property (!req_valid_in |=> !resp_valid_out)
    else $error("response without request");
  a_soft_sum_or: assert property (s_ques_req |=> resp_data_out[11] == (|resp_data_out[3:1]))
    else $error("soft summary wrong");
  a_hard_sum_or: assert property (s_ques_req |=> resp_data_out[12] == (|{resp_data_out[6:4], resp_data_out[0]}))
    else $error("hard summary wrong");
  a_ques_upper_zero: assert property (s_ques_req |=> resp_data_out[31:16] == 16'h0000)
    else $error("upper questionable bits set");
  a_ques_write_err: assert property (req_valid_in && req_write_in && req_instance_in == INST_QUES_RD |=> resp_status_out == ST_ERR)
    else $error("write to questionable accepted");
  a_live_write_err: assert property (req_valid_in && req_write_in && req_instance_in == INST_LIVE_RD |=> resp_status_out == ST_ERR)
    else $error("write to live status accepted");
  a_restore_read_err: assert property (req_valid_in && !req_write_in && req_instance_in == INST_RESTORE_WR |=> resp_status_out == ST_ERR)
    else $error("read of restore accepted");
  a_locked_hold: assert property (s_locked_set |=> resp_status_out == ST_ERR ##1 $stable(current_target_out))
    else $error("set-point changed while locked");
endmodule
bind supply_network_object_map supply_map_assertions #(.NUM_PARAMS(NUM_PARAMS)) u_chk (.clk_in(clk_in),
  .reset_n_in(reset_n_in), .req_valid_in(req_valid_in), .req_write_in(req_write_in), .req_instance_in(req_instance_in),
  .resp_valid_out(resp_valid_out), .resp_status_out(resp_status_out), .resp_data_out(resp_data_out),
  .current_target_out(current_target_out), .lock_out(lock_out));

/* File: verification/network_originator.sv */
`timescale 1ns/10ps
module network_originator
  import supply_map_pkg::*;
(
  input wire logic clk_in,
  output logic req_valid_out,
  output logic req_write_out,
  output logic [INST_W-1:0] req_instance_out,
  output logic [DATA_W-1:0] req_data_out
);
  initial begin
    req_valid_out = 1'b0;
    req_write_out = 1'b0;
    req_instance_out = 12'h000;
    req_data_out = 32'h0000_0000;
  end
  // fields held through the taking edge; idle data scrambled so stale values never pass
  task automatic req(input logic w, input logic [INST_W-1:0] inst, input logic [DATA_W-1:0] d);
    @(posedge clk_in);
    req_valid_out <= 1'b1;
    req_write_out <= w;
    req_instance_out <= inst;
    req_data_out <= d;
    @(posedge clk_in);
    req_valid_out <= 1'b0;
    req_data_out <= ~d;
  endtask
endmodule

/* File: verification/tb_supply_network_object_map.sv */
`timescale 1ns/10ps
module tb_supply_network_object_map;
  import supply_map_pkg::*;
  localparam logic [11:0] WR_TAB [16] = '{12'h201, 12'h203, 12'h205, 12'h301, 12'h303, 12'h305, 12'h307, 12'h401,
    12'h403, 12'h405, 12'h409, 12'h40B, 12'h40D, 12'h503, 12'h706, 12'h70A};
  localparam logic [11:0] RO_TAB [6] = '{12'h00B, 12'h00D, 12'h101, 12'h102, 12'h103, 12'h7FF};
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic req_valid_in, req_write_in, interlock_open_in, input_power_loss_in, user_input_fault_in, power_active_in;
  logic [INST_W-1:0] req_instance_in;
  logic [6:0] fault_flags_in;
  logic [3:0] regulation_state_in;
  logic [DATA_W-1:0] req_data_in, live_status_in, read_avg_current_in, read_avg_voltage_in, read_dc_power_in, r;
  logic [16*DATA_W-1:0] factory_defaults_in;
  logic resp_valid_out, output_enable_out, lock_out;
  logic [1:0] resp_status_out;
  logic [DATA_W-1:0] resp_data_out, current_target_out, voltage_target_out, power_target_out, active_up_slew_out;
  logic [DATA_W-1:0] active_down_slew_out, control_selection_out, sense_location_cfg_out, target_origin_select_out;
  logic [DATA_W-1:0] pv [16];
  logic [33:0] exp_q [$];
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  int seed;
  supply_network_object_map #(.NUM_PARAMS(16)) u_dut (.clk_in, .reset_n_in, .req_valid_in, .req_write_in,
    .req_instance_in, .req_data_in, .fault_flags_in, .regulation_state_in, .interlock_open_in, .input_power_loss_in,
    .user_input_fault_in, .power_active_in, .live_status_in, .read_avg_current_in, .read_avg_voltage_in,
    .read_dc_power_in, .factory_defaults_in, .resp_valid_out, .resp_status_out, .resp_data_out, .output_enable_out,
    .current_target_out, .voltage_target_out, .power_target_out, .active_up_slew_out, .active_down_slew_out,
    .control_selection_out, .sense_location_cfg_out, .target_origin_select_out, .lock_out);
  network_originator u_orig (.clk_in, .req_valid_out(req_valid_in), .req_write_out(req_write_in),
    .req_instance_out(req_instance_in), .req_data_out(req_data_in));
  initial forever #25 clk_in = ~clk_in;
  task automatic summarize();
    if (failures == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk_resp(input logic [33:0] e, input logic [33:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic chk_val(input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic tx(input logic w, input logic [11:0] inst, input logic [31:0] d, input logic [33:0] e);
    exp_q.push_back(e);
    u_orig.req(w, inst, d);
  endtask
  function automatic logic [31:0] ques_exp();
    logic [6:0] f = fault_flags_in;
    return {16'h0000, user_input_fault_in, input_power_loss_in, interlock_open_in, f[0] | f[4] | f[5] | f[6],
      |f[3:1], regulation_state_in, f};
  endfunction
  // responses in request order, so the oldest note always matches
  always @(posedge clk_in) begin
    if (resp_valid_out === 1'b1) chk_resp(exp_q.size() > 0 ? exp_q.pop_front() : 34'h3_FFFF_FFFF,
      {resp_status_out, resp_data_out});
  end
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      summarize();
    end
  end
  initial begin
    seed = 98;
    {fault_flags_in, regulation_state_in, interlock_open_in, input_power_loss_in, user_input_fault_in} = '0;
    power_active_in = 1'b1;
    {live_status_in, read_avg_current_in, read_avg_voltage_in, read_dc_power_in} = '0;
    for (int k = 0; k < 16; k++) factory_defaults_in[k*32+:32] = $random(seed);
    repeat (3) @(posedge clk_in);
    reset_n_in <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      @(posedge clk_in);
      r = $random(seed);
      {user_input_fault_in, input_power_loss_in, interlock_open_in, regulation_state_in, fault_flags_in} <= r[13:0];
      live_status_in <= $random(seed);
      read_avg_current_in <= $random(seed);
      read_avg_voltage_in <= $random(seed);
      read_dc_power_in <= $random(seed);
      repeat (4) @(posedge clk_in);
      tx(1'b0, INST_QUES_RD, 32'h0, {ST_OK, ques_exp()});
      tx(1'b0, INST_QUES_RD, 32'h0, {ST_OK, ques_exp()});
      tx(1'b0, INST_LIVE_RD, 32'h0, {ST_OK, live_status_in});
      tx(1'b0, INST_CURR_RD, 32'h0, {ST_OK, read_avg_current_in});
      tx(1'b0, INST_VOLT_RD, 32'h0, {ST_OK, read_avg_voltage_in});
      tx(1'b0, INST_PWR_RD, 32'h0, {ST_OK, read_dc_power_in});
    end
    for (int k = 0; k < 16; k++) begin
      pv[k] = $random(seed);
      tx(1'b1, WR_TAB[k], pv[k], {ST_OK, 32'h0});
      tx(1'b0, WR_TAB[k] + 12'h001, 32'h0, {ST_OK, pv[k]});
    end
    foreach (RO_TAB[k]) tx(1'b1, RO_TAB[k], 32'h0000_FFFF, {ST_ERR, 32'h0});
    tx(1'b0, INST_RESTORE_WR, 32'h0, {ST_ERR, 32'h0});
    tx(1'b0, 12'h202, 32'h0, {ST_OK, pv[0]});
    tx(1'b1, INST_LOCK_WR, 32'h1, {ST_OK, 32'h0});
    tx(1'b0, INST_LOCK_RD, 32'h0, {ST_OK, 32'h1});
    chk_val(32'h1, 32'(lock_out));
    tx(1'b1, 12'h201, 32'h1234_5678, {ST_ERR, 32'h0});
    tx(1'b1, INST_RESTORE_WR, 32'h0, {ST_ERR, 32'h0});
    tx(1'b0, 12'h202, 32'h0, {ST_OK, pv[0]});
    tx(1'b1, INST_LOCK_WR, 32'h0, {ST_OK, 32'h0});
    tx(1'b1, INST_RESTORE_WR, 32'h0, {ST_OK, 32'h0});
    for (int k = 0; k < 16; k++) tx(1'b0, WR_TAB[k] + 12'h001, 32'h0, {ST_OK, factory_defaults_in[k*32+:32]});
    chk_val(factory_defaults_in[31:0], current_target_out);
    chk_val(factory_defaults_in[63:32], voltage_target_out);
    chk_val(factory_defaults_in[95:64], power_target_out);
    chk_val(factory_defaults_in[13*32+:32], control_selection_out);
    chk_val(factory_defaults_in[14*32+:32], sense_location_cfg_out);
    chk_val(factory_defaults_in[15*32+:32], target_origin_select_out);
    chk_val(32'h0, 32'(lock_out));
    @(posedge clk_in);
    fault_flags_in <= 7'h00;
    regulation_state_in <= 4'h1;
    repeat (4) @(posedge clk_in);
    chk_val(factory_defaults_in[7*32+:32], active_up_slew_out);
    chk_val(factory_defaults_in[10*32+:32], active_down_slew_out);
    tx(1'b1, INST_OUT_WR, 32'h1, {ST_OK, 32'h0});
    tx(1'b0, INST_OUT_RD, 32'h0, {ST_OK, 32'h1});
    @(posedge clk_in);
    chk_val(32'h1, 32'(output_enable_out));
    power_active_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    tx(1'b0, INST_OUT_RD, 32'h0, {ST_OK, 32'h0});
    repeat (3) @(posedge clk_in);
    if (exp_q.size() != 0) failures++;
    summarize();
  end
endmodule
